//--- ipc_pkg.sv
// Package with register map, field layout and carrier types of the interrupt priority block.
package ipc_pkg;
	localparam int IPC_NSRC = 16;
	localparam int IPC_NPAIR = 8;
	localparam int IPC_NEXT = 5;
	localparam logic [11:0] IPC_OFS_MODE = 12'h08c;
	localparam logic [11:0] IPC_OFS_TB0 = 12'h099;
	localparam logic [11:0] IPC_OFS_TB1 = 12'h09a;
	localparam logic [11:0] IPC_OFS_TBO = 12'h09b;
	localparam logic [11:0] IPC_OFS_SER0 = 12'h09c;
	localparam logic [11:0] IPC_OFS_SER1 = 12'h09d;
	localparam logic [11:0] IPC_OFS_SBRTC = 12'h09e;
	localparam logic [11:0] IPC_OFS_DMA01 = 12'h0a0;
	localparam logic [11:0] IPC_OFS_DMA23 = 12'h0a1;
	localparam logic [11:0] IPC_OFS_STAT = 12'h0c0;
	localparam logic [11:0] IPC_OFS_MASK = 12'h0c4;
	localparam logic [7:0] IPC_MODE_RST = 8'h00;
	localparam logic [7:0] IPC_PAIR_RST = 8'h00;
	localparam logic [2:0] IPC_PRIO_RST = 3'h0;
	localparam int IPC_NMI_BOTH_BIT = 0;
	localparam int IPC_EXT0_LEVEL_BIT = 1;
	localparam int IPC_EDGE_LSB = 2;
	localparam int IPC_LO_FLAG_BIT = 3;
	localparam int IPC_HI_FLAG_BIT = 7;
	localparam int IPC_HI_PRIO_LSB = 4;
	localparam logic [2:0] IPC_PRIO_OFF_LO = 3'h0;
	localparam logic [2:0] IPC_PRIO_OFF_HI = 3'h7;
	localparam int IPC_NEV = 2;
	localparam logic [1:0] IPC_EV_RST = 2'h0;
	typedef struct packed {
		logic [2:0] level;
		logic enabled;
	} ipc_prio_s;
	typedef struct packed {
		logic [11:0] addr;
		logic write;
		logic sel;
		logic enable;
		logic [31:0] wdata;
	} ipc_apb_req_s;
endpackage : ipc_pkg

//--- ipc_prio_decode.sv
// Priority field decoder for one interrupt source.
`timescale 1ns/100ps
module ipc_prio_decode import ipc_pkg::*; (
	input wire logic [2:0] i_field,
	output ipc_prio_s o_prio
);
	// Codes zero and seven both mean the source is switched off.
	always_comb begin
		o_prio.level = i_field;
		o_prio.enabled = (i_field != IPC_PRIO_OFF_LO) && (i_field != IPC_PRIO_OFF_HI);
	end
endmodule : ipc_prio_decode

//--- ipc_edge_detect.sv
// Synchroniser and edge detector for one external interrupt pin.
`timescale 1ns/100ps
module ipc_edge_detect (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_pin,
	output logic o_level,
	output logic o_rise,
	output logic o_fall
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
		end else begin
			s1_reg <= i_pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end
	assign o_level = s2_reg;
	assign o_rise = s2_reg & ~s3_reg;
	assign o_fall = ~s2_reg & s3_reg;
endmodule : ipc_edge_detect

//--- ipc_top.sv
// Interrupt enable, priority and external edge control with an APB register port.
// Summary of operation
// - Each source's 3-bit priority field gives level one to six, and codes zero and seven disable it.
// - With the both-edges bit clear, a non-maskable request comes only on a falling input edge.
// - With the both-edges bit set, a non-maskable request comes on rising and falling edges.
// - Two sources share each 8-bit enable register, upper in bits 7-4, lower in bits 3-0, flag above field.
// - In level mode external interrupt 0 bypasses its latch and follows the pin level.
//
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
module ipc_top import ipc_pkg::*; (
	input wire logic I_CLK,
	input wire logic I_RST_N,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [11:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	input wire logic [IPC_NSRC-1:0] I_SRC_REQ,
	input wire logic [IPC_NSRC-1:0] I_SRC_CLR,
	input wire logic [IPC_NEXT-1:0] I_EXT_PIN,
	input wire logic I_NMI_PIN,
	output logic [IPC_NSRC-1:0] O_SRC_ACTIVE,
	output logic [3*IPC_NSRC-1:0] O_SRC_LEVEL,
	output logic [IPC_NEXT-1:0] O_EXT_IRQ,
	output logic O_NMI_REQ,
	output logic O_IRQ
);
	ipc_apb_req_s req;
	logic [7:0] mode_reg;
	logic [2:0] prio_reg [IPC_NSRC];
	logic [IPC_NSRC-1:0] flag_reg;
	logic [IPC_NEXT-1:0] ext_flag_reg;
	logic [IPC_NEV-1:0] stat_reg;
	logic [IPC_NEV-1:0] mask_reg;
	logic nmi_req_reg;
	logic [IPC_NEXT-1:0] ext_lvl;
	logic [IPC_NEXT-1:0] ext_rise;
	logic [IPC_NEXT-1:0] ext_fall;
	logic [IPC_NEXT-1:0] ext_edge;
	logic nmi_lvl;
	logic nmi_rise;
	logic nmi_fall;
	logic nmi_event;
	logic wr_en;
	logic rd_hit;
	logic pair_hit;
	logic [2:0] pair_idx;
	logic [IPC_NEV-1:0] ev;
	logic [31:0] rdata_next;
	logic acc_ok;
	logic [11:0] reg_idx;
	ipc_prio_s prio [IPC_NSRC];

	assign req = '{addr: I_PADDR, write: I_PWRITE, sel: I_PSEL, enable: I_PENABLE,
		wdata: I_PWDATA};
	// Each register takes one aligned word, so its byte address is four times its index.
	assign reg_idx = {2'b00, req.addr[11:2]};
	assign acc_ok = (req.addr[1:0] == 2'b00);
	assign wr_en = req.sel & req.enable & req.write & acc_ok;
	assign O_PREADY = 1'b1;
	assign O_PSLVERR = 1'b0;

	// Pair registers sit at consecutive indices, a hole at index 0x9f splits the two groups.
	always_comb begin
		pair_hit = acc_ok;
		pair_idx = 3'd0;
		case (reg_idx)
			IPC_OFS_TB0: pair_idx = 3'd0;
			IPC_OFS_TB1: pair_idx = 3'd1;
			IPC_OFS_TBO: pair_idx = 3'd2;
			IPC_OFS_SER0: pair_idx = 3'd3;
			IPC_OFS_SER1: pair_idx = 3'd4;
			IPC_OFS_SBRTC: pair_idx = 3'd5;
			IPC_OFS_DMA01: pair_idx = 3'd6;
			IPC_OFS_DMA23: pair_idx = 3'd7;
			default: pair_hit = 1'b0;
		endcase
	end

	genvar g;
	generate
		for (g = 0; g < IPC_NEXT; g++) begin : g_ext
			ipc_edge_detect u_det (
				.i_clk(I_CLK),
				.i_rst_n(I_RST_N),
				.i_pin(I_EXT_PIN[g]),
				.o_level(ext_lvl[g]),
				.o_rise(ext_rise[g]),
				.o_fall(ext_fall[g])
			);
			// A set edge-select bit means falling edge, clear means rising edge.
			assign ext_edge[g] = mode_reg[IPC_EDGE_LSB+g] ? ext_fall[g] : ext_rise[g];
		end
		for (g = 0; g < IPC_NSRC; g++) begin : g_src
			ipc_prio_decode u_dec (
				.i_field(prio_reg[g]),
				.o_prio(prio[g])
			);
			assign O_SRC_ACTIVE[g] = flag_reg[g] & prio[g].enabled;
			assign O_SRC_LEVEL[3*g +: 3] = prio[g].enabled ? prio[g].level : 3'h0;
		end
	endgenerate

	ipc_edge_detect u_nmi (
		.i_clk(I_CLK),
		.i_rst_n(I_RST_N),
		.i_pin(I_NMI_PIN),
		.o_level(nmi_lvl),
		.o_rise(nmi_rise),
		.o_fall(nmi_fall)
	);

	// Falling edge always counts; rising edge only when both edges are selected.
	assign nmi_event = nmi_fall | (mode_reg[IPC_NMI_BOTH_BIT] & nmi_rise);

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			mode_reg <= IPC_MODE_RST;
		end else if (wr_en && reg_idx == IPC_OFS_MODE) begin
			mode_reg <= {1'b0, req.wdata[6:0]};
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			for (int i = 0; i < IPC_NSRC; i++) begin
				prio_reg[i] <= IPC_PRIO_RST;
			end
		end else if (wr_en && pair_hit) begin
			prio_reg[2*pair_idx] <= req.wdata[2:0];
			prio_reg[2*pair_idx+1] <= req.wdata[IPC_HI_PRIO_LSB +: 3];
		end
	end

	// Request flags are read-only from the bus; a new request wins over a clear.
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			flag_reg <= '0;
		end else begin
			flag_reg <= I_SRC_REQ | (flag_reg & ~I_SRC_CLR);
		end
	end

	// External 0 still latches here, but in level mode its output bypasses the latch, so its request drops with the pin.
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			ext_flag_reg <= '0;
		end else begin
			ext_flag_reg <= ext_edge | (ext_flag_reg & ~I_SRC_CLR[IPC_NEXT-1:0]);
		end
	end

	always_comb begin
		O_EXT_IRQ = ext_flag_reg;
		if (mode_reg[IPC_EXT0_LEVEL_BIT]) begin
			O_EXT_IRQ[0] = ext_lvl[0];
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			nmi_req_reg <= 1'b0;
		end else begin
			nmi_req_reg <= nmi_event;
		end
	end
	assign O_NMI_REQ = nmi_req_reg;

	// Status: bit 0 non-maskable event, bit 1 any external edge; write one to clear.
	assign ev = {|ext_edge, nmi_event};
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			stat_reg <= IPC_EV_RST;
		end else begin
			if (wr_en && reg_idx == IPC_OFS_STAT) begin
				stat_reg <= (stat_reg & ~req.wdata[IPC_NEV-1:0]) | ev;
			end else begin
				stat_reg <= stat_reg | ev;
			end
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			mask_reg <= IPC_EV_RST;
		end else if (wr_en && reg_idx == IPC_OFS_MASK) begin
			mask_reg <= req.wdata[IPC_NEV-1:0];
		end
	end
	assign O_IRQ = |(stat_reg & mask_reg);

	// The mode register is write-only and reads as zero.
	always_comb begin
		rdata_next = 32'h0000_0000;
		rd_hit = 1'b0;
		if (pair_hit) begin
			rd_hit = 1'b1;
			rdata_next[IPC_HI_FLAG_BIT] = flag_reg[2*pair_idx+1];
			rdata_next[IPC_HI_PRIO_LSB +: 3] = prio_reg[2*pair_idx+1];
			rdata_next[IPC_LO_FLAG_BIT] = flag_reg[2*pair_idx];
			rdata_next[2:0] = prio_reg[2*pair_idx];
		end else if (acc_ok && reg_idx == IPC_OFS_STAT) begin
			rd_hit = 1'b1;
			rdata_next[IPC_NEV-1:0] = stat_reg;
		end else if (acc_ok && reg_idx == IPC_OFS_MASK) begin
			rd_hit = 1'b1;
			rdata_next[IPC_NEV-1:0] = mask_reg;
		end
	end

	// Read data is registered in the setup cycle so it is stable during the access phase.
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_PRDATA <= 32'h0000_0000;
		end else if (req.sel && !req.enable && !req.write) begin
			O_PRDATA <= rd_hit ? rdata_next : 32'h0000_0000;
		end
	end

	nmi_falling_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		$fell(nmi_lvl) |=> O_NMI_REQ) else $error("nmi falling edge lost");
	nmi_rise_only_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		($rose(nmi_lvl) && !mode_reg[IPC_NMI_BOTH_BIT]) |=> !O_NMI_REQ)
		else $error("nmi rising edge fired in single mode");
	nmi_both_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		($rose(nmi_lvl) && mode_reg[IPC_NMI_BOTH_BIT]) |=> O_NMI_REQ)
		else $error("nmi rising edge lost in both mode");
	nmi_quiet_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(!nmi_rise && !nmi_fall) |=> !O_NMI_REQ) else $error("nmi request without edge");
	nmi_single_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		!mode_reg[IPC_NMI_BOTH_BIT] |=> (O_NMI_REQ == $past(nmi_fall)))
		else $error("nmi single edge mode wrong");
	nmi_both_edges_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		mode_reg[IPC_NMI_BOTH_BIT] |=> (O_NMI_REQ == ($past(nmi_rise) || $past(nmi_fall))))
		else $error("nmi both edge mode wrong");

	prio_off_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(prio_reg[9] == 3'h7 || prio_reg[9] == 3'h0) |-> !O_SRC_ACTIVE[9])
		else $error("disabled source active");
	prio_on_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(prio_reg[9] == 3'h3 && flag_reg[9]) |-> (O_SRC_ACTIVE[9] && O_SRC_LEVEL[29:27] == 3'h3))
		else $error("enabled source not active");
	level_off_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(prio_reg[9] == 3'h7 || prio_reg[9] == 3'h0) |-> (O_SRC_LEVEL[29:27] == 3'h0))
		else $error("disabled source shows a level");
	level_on_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(prio_reg[8] != 3'h0 && prio_reg[8] != 3'h7) |-> (O_SRC_LEVEL[26:24] == prio_reg[8]))
		else $error("enabled source level wrong");

	pair_write_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(wr_en && reg_idx == IPC_OFS_SER1) |=> (prio_reg[9] == $past(req.wdata[6:4])
		&& prio_reg[8] == $past(req.wdata[2:0]))) else $error("pair field write wrong");
	prio_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		!(wr_en && pair_hit) |=> ($stable(prio_reg[9]) && $stable(prio_reg[8])))
		else $error("priority field changed without write");
	pair_read_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(req.sel && !req.enable && !req.write && acc_ok && reg_idx == IPC_OFS_SER1)
		|=> (O_PRDATA[7:0] == {$past(flag_reg[9]), $past(prio_reg[9]), $past(flag_reg[8]),
		$past(prio_reg[8])})) else $error("pair read layout wrong");
	flag_set_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		I_SRC_REQ[9] |=> flag_reg[9]) else $error("source request flag not set");
	flag_clear_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(I_SRC_CLR[9] && !I_SRC_REQ[9]) |=> !flag_reg[9]) else $error("source flag not cleared");

	ext_fall_sel_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(mode_reg[IPC_EDGE_LSB+1] && ext_fall[1]) |=> O_EXT_IRQ[1])
		else $error("ext falling edge lost");
	ext_rise_sel_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(!mode_reg[IPC_EDGE_LSB+1] && ext_rise[1]) |=> O_EXT_IRQ[1])
		else $error("ext rising edge lost");
	ext_fall_only_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(mode_reg[IPC_EDGE_LSB+1] && !ext_fall[1] && !O_EXT_IRQ[1]) |=> !O_EXT_IRQ[1])
		else $error("ext request without falling edge");
	ext_rise_only_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(!mode_reg[IPC_EDGE_LSB+1] && !ext_rise[1] && !O_EXT_IRQ[1]) |=> !O_EXT_IRQ[1])
		else $error("ext request without rising edge");
	ext_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(O_EXT_IRQ[1] && !I_SRC_CLR[1]) |=> O_EXT_IRQ[1]) else $error("ext request dropped");
	ext_clear_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(I_SRC_CLR[1] && !ext_edge[1]) |=> !O_EXT_IRQ[1]) else $error("ext request not cleared");
	mode_write_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(wr_en && reg_idx == IPC_OFS_MODE) |=> (mode_reg == {1'b0, $past(req.wdata[6:0])}))
		else $error("mode write wrong");
	mode_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		!(wr_en && reg_idx == IPC_OFS_MODE) |=> $stable(mode_reg))
		else $error("mode changed without write");

	ext0_level_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		mode_reg[IPC_EXT0_LEVEL_BIT] |-> (O_EXT_IRQ[0] == ext_lvl[0]))
		else $error("ext0 level mode not following pin");
	ext0_latch_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		!mode_reg[IPC_EXT0_LEVEL_BIT] |-> (O_EXT_IRQ[0] == ext_flag_reg[0]))
		else $error("ext0 edge mode not latched");

	stat_set_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		nmi_event |=> stat_reg[0]) else $error("status event lost");
	stat_clear_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
		(wr_en && reg_idx == IPC_OFS_STAT && req.wdata[0] && !nmi_event) |=> !stat_reg[0])
		else $error("status not cleared");
endmodule : ipc_top

//--- ipc_pin_model.sv
// Model of the pins and peripheral sources that face the interrupt controller.
`timescale 1ns/100ps
module ipc_pin_model import ipc_pkg::*; (
	input wire logic i_clk,
	output logic [IPC_NSRC-1:0] o_src_req,
	output logic [IPC_NSRC-1:0] o_src_clr,
	output logic [IPC_NEXT-1:0] o_ext_pin,
	output logic o_nmi_pin
);
	initial begin
		o_src_req = '0;
		o_src_clr = '0;
		o_ext_pin = '0;
		o_nmi_pin = 1'b0;
	end
	// Pins are held for six cycles so that each level clears the two-flop synchroniser.
	task drive(input logic [IPC_NEXT-1:0] ext, input logic nmi);
		@(posedge i_clk);
		o_ext_pin <= ext;
		o_nmi_pin <= nmi;
		repeat (6) @(posedge i_clk);
	endtask : drive
	task pulse(input logic [IPC_NSRC-1:0] req, input logic [IPC_NSRC-1:0] clr);
		@(posedge i_clk);
		o_src_req <= req;
		o_src_clr <= clr;
		@(posedge i_clk);
		o_src_req <= '0;
		o_src_clr <= '0;
		repeat (2) @(posedge i_clk);
	endtask : pulse
endmodule : ipc_pin_model

//--- test_interrupt_priority_and_edge_control.sv
// Self-checking bench for the interrupt priority and edge control block.
`timescale 1ns/100ps
module test_interrupt_priority_and_edge_control import ipc_pkg::*; ;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, nmi_req, irq, nmi_pin;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [IPC_NSRC-1:0] src_req, src_clr, active;
	logic [3*IPC_NSRC-1:0] level;
	logic [IPC_NEXT-1:0] ext_pin, ext_irq;
	logic [11:0] ofs [8] = '{IPC_OFS_TB0, IPC_OFS_TB1, IPC_OFS_TBO, IPC_OFS_SER0,
		IPC_OFS_SER1, IPC_OFS_SBRTC, IPC_OFS_DMA01, IPC_OFS_DMA23};
	int num_errors = 0;
	int comparisons = 0;
	int nmi_cnt = 0;
	ipc_top dut (.I_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
		.I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr), .I_SRC_REQ(src_req), .I_SRC_CLR(src_clr),
		.I_EXT_PIN(ext_pin), .I_NMI_PIN(nmi_pin), .O_SRC_ACTIVE(active), .O_SRC_LEVEL(level),
		.O_EXT_IRQ(ext_irq), .O_NMI_REQ(nmi_req), .O_IRQ(irq));
	ipc_pin_model pins (.i_clk(clk), .o_src_req(src_req), .o_src_clr(src_clr),
		.o_ext_pin(ext_pin), .o_nmi_pin(nmi_pin));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) if (nmi_req === 1'b1) nmi_cnt <= nmi_cnt + 1;
	task report_and_stop;
		$display("errors %0d, comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop
	task check(input string what, input logic [47:0] seen, input logic [47:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check
	// The request is held until pready is seen high, so a slower slave is also served.
	// Offsets are word indices; outputs are looked at on the falling edge, once settled.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {a[9:0], 2'b00};
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge clk);
		if (n >= 20) begin
			num_errors++;
			report_and_stop();
		end
	endtask : apb
	task rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		check(what, rd, exp);
	endtask : rdc
	function automatic logic [2:0] lv(input int v);
		return (v == 0 || v == 7) ? 3'h0 : 3'(v);
	endfunction : lv
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		report_and_stop();
	end
	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		foreach (ofs[i]) rdc("pair reset", ofs[i], 32'h0000_0000);
		rdc("mode read", IPC_OFS_MODE, 32'h0000_0000);
		rdc("unmapped", 12'h0b0, 32'h0000_0000);
		check("slave error", 48'(pslverr), 48'h0000_0000_0000);
		for (int c = 0; c < 8; c++) begin
			apb(1'b1, IPC_OFS_SER1, {24'h0000_00, 1'b1, 3'(c), 1'b1, 3'(7 - c)});
			rdc("pair", IPC_OFS_SER1, {24'h0000_00, 1'b0, 3'(c), 1'b0, 3'(7 - c)});
			check("level", 48'(level[29:24]), 48'({lv(c), lv(7 - c)}));
		end
		apb(1'b1, IPC_OFS_SER1, 32'h0000_0030);
		pins.pulse(16'h0200, 16'h0000);
		rdc("flag", IPC_OFS_SER1, 32'h0000_00b0);
		check("active", 48'(active[9]), 48'h0000_0000_0001);
		apb(1'b1, IPC_OFS_SER1, 32'h0000_0070);
		check("active off", 48'(active[9]), 48'h0000_0000_0000);
		pins.pulse(16'h0000, 16'h0200);
		rdc("flag clear", IPC_OFS_SER1, 32'h0000_0070);
		pins.drive(5'h00, 1'b1);
		pins.drive(5'h00, 1'b0);
		check("nmi fall only", 48'(nmi_cnt), 48'h0000_0000_0001);
		apb(1'b1, IPC_OFS_MODE, 32'h0000_0001);
		rdc("mode write only", IPC_OFS_MODE, 32'h0000_0000);
		pins.drive(5'h00, 1'b1);
		pins.drive(5'h00, 1'b0);
		check("nmi both", 48'(nmi_cnt), 48'h0000_0000_0003);
		rdc("status", IPC_OFS_STAT, 32'h0000_0001);
		check("irq masked", 48'(irq), 48'h0000_0000_0000);
		apb(1'b1, IPC_OFS_MASK, 32'h0000_0001);
		check("irq", 48'(irq), 48'h0000_0000_0001);
		apb(1'b1, IPC_OFS_STAT, 32'h0000_0001);
		check("irq cleared", 48'(irq), 48'h0000_0000_0000);
		apb(1'b1, IPC_OFS_MODE, 32'h0000_0000);
		pins.drive(5'h02, 1'b0);
		check("ext rise", 48'(ext_irq[1]), 48'h0000_0000_0001);
		pins.pulse(16'h0000, 16'h0002);
		pins.drive(5'h00, 1'b0);
		check("ext no fall", 48'(ext_irq[1]), 48'h0000_0000_0000);
		apb(1'b1, IPC_OFS_MODE, 32'h0000_0008);
		pins.drive(5'h02, 1'b0);
		check("ext no rise", 48'(ext_irq[1]), 48'h0000_0000_0000);
		pins.drive(5'h00, 1'b0);
		check("ext fall", 48'(ext_irq[1]), 48'h0000_0000_0001);
		apb(1'b1, IPC_OFS_MODE, 32'h0000_0002);
		pins.drive(5'h01, 1'b0);
		check("level high", 48'(ext_irq[0]), 48'h0000_0000_0001);
		pins.drive(5'h00, 1'b0);
		check("level low", 48'(ext_irq[0]), 48'h0000_0000_0000);
		report_and_stop();
	end
endmodule : test_interrupt_priority_and_edge_control
